//--- branch_exec.sv
// executes the nz relative jump, the pointer-pair jumps and the
// decrement-and-loop branch; one ref_clk cycle stands for one t-state
// assumes the caller holds the fetched bytes and register view on
// req while start is high, and writes res back on done
`include "branch_consts.svh"
`timescale 1ns/100ps
module branch_exec (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // request
  input wire logic start,
  input wire branch_pkg::branch_req_t req,
  // status and result
  output logic busy,
  output logic done,
  output branch_pkg::branch_res_t res
);

  // ----------------------------------------------------------------
  // target arithmetic
  // ----------------------------------------------------------------
  logic [15:0] rel_target;
  logic [15:0] rel_next;

  disp_adder u_disp_adder (
    .op_addr(req.op_addr),
    .disp(req.op1),
    .target(rel_target),
    .seq_next(rel_next)
  );

  // ----------------------------------------------------------------
  // decode: result and duration worked out when the request is taken
  // ----------------------------------------------------------------
  branch_pkg::branch_res_t dec_res;
  logic [3:0] dec_len;
  logic [7:0] count_dec;

  always_comb begin
    count_dec = req.loop_count - `COUNT_ONE;
    dec_res.next_pointer = req.op_addr + `STEP_ONE;
    dec_res.loop_count = req.loop_count;
    dec_res.loop_count_wr = 1'b0;
    // flags pass through untouched on every path
    dec_res.flags = req.flags;
    dec_res.taken = 1'b0;
    dec_res.unknown_op = 1'b0;
    dec_len = `TS_UNKNOWN;
    case (req.op0)
      `OP_REL_NZ: begin
        if (!req.zero_flag) begin
          dec_res.next_pointer = rel_target;
          dec_res.taken = 1'b1;
          dec_len = `TS_REL_TAKEN;
        end else begin
          dec_res.next_pointer = rel_next;
          dec_len = `TS_REL_SKIP;
        end
      end
      `OP_LOOP: begin
        // the decrement leaves the flags alone as well
        dec_res.loop_count = count_dec;
        dec_res.loop_count_wr = 1'b1;
        if (count_dec != `COUNT_ZERO) begin
          dec_res.next_pointer = rel_target;
          dec_res.taken = 1'b1;
          dec_len = `TS_LOOP_TAKEN;
        end else begin
          dec_res.next_pointer = rel_next;
          dec_len = `TS_LOOP_SKIP;
        end
      end
      `OP_PTR_JUMP: begin
        dec_res.next_pointer = req.primary_pair;
        dec_res.taken = 1'b1;
        dec_len = `TS_PTR;
      end
      `OP_PFX_FIRST: begin
        if (req.op1 == `OP_PTR_JUMP) begin
          dec_res.next_pointer = req.first_index;
          dec_res.taken = 1'b1;
          dec_len = `TS_IDX;
        end else begin
          dec_res.unknown_op = 1'b1;
        end
      end
      `OP_PFX_SECOND: begin
        if (req.op1 == `OP_PTR_JUMP) begin
          dec_res.next_pointer = req.second_index;
          dec_res.taken = 1'b1;
          dec_len = `TS_IDX;
        end else begin
          dec_res.unknown_op = 1'b1;
        end
      end
      default: begin
        // outside this group: step past the opcode, report it
        dec_res.unknown_op = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  branch_pkg::exec_state_t state_ff;
  branch_pkg::exec_state_t nxt_state;
  logic [3:0] tcnt_ff;
  logic [3:0] nxt_tcnt;
  logic busy_ff;
  logic nxt_busy;
  logic done_ff;
  logic nxt_done;
  branch_pkg::branch_res_t res_ff;
  branch_pkg::branch_res_t nxt_res;
  branch_pkg::branch_res_t hold_ff;
  branch_pkg::branch_res_t nxt_hold;
  logic take_req;
  logic last_state;

  // a request is looked at only while idle; one raised while busy
  // is lost with no sign at the ports, so callers wait for done
  // take_req and last_state never hold together
  assign take_req = (state_ff == branch_pkg::ST_IDLE) && start;
  assign last_state = (state_ff == branch_pkg::ST_EXEC) &&
    (tcnt_ff == `CNT_ZERO);

  // ----------------------------------------------------------------
  // control: state, busy and done
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    case (state_ff)
      branch_pkg::ST_IDLE: begin
        if (take_req) begin
          nxt_busy = 1'b1;
          nxt_state = branch_pkg::ST_EXEC;
        end
      end
      branch_pkg::ST_EXEC: begin
        if (last_state) begin
          nxt_done = 1'b1;
          nxt_busy = 1'b0;
          nxt_state = branch_pkg::ST_IDLE;
        end
      end
      default: begin
        // only reached from a corrupted state register
        nxt_state = branch_pkg::ST_IDLE;
        nxt_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= branch_pkg::ST_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // t-state counter: loaded with the total minus one
  // ----------------------------------------------------------------
  // four bits cover the longest instruction of the group
  always_comb begin
    nxt_tcnt = tcnt_ff;
    if (take_req) begin
      nxt_tcnt = dec_len;
    end else if ((state_ff == branch_pkg::ST_EXEC) && !last_state) begin
      nxt_tcnt = tcnt_ff - `CNT_STEP;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tcnt_ff <= `CNT_ZERO;
    end else begin
      tcnt_ff <= nxt_tcnt;
    end
  end

  // ----------------------------------------------------------------
  // result: decoded when taken, shown with done
  // ----------------------------------------------------------------
  // hold keeps the decode, so req may change once it is taken;
  // res keeps its value between instructions for a late reader
  always_comb begin
    nxt_hold = hold_ff;
    nxt_res = res_ff;
    if (take_req) begin
      nxt_hold = dec_res;
    end
    if (last_state) begin
      // result only shows once the full state count has run
      nxt_res = hold_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      res_ff <= '0;
      hold_ff <= '0;
    end else begin
      res_ff <= nxt_res;
      hold_ff <= nxt_hold;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a register
  // ----------------------------------------------------------------
  assign busy = busy_ff;
  assign done = done_ff;
  assign res = res_ff;

endmodule

//--- branch_consts.svh
// constants for the relative and indirect branch executor
// assumes one t-state per ref_clk cycle, fetch done by the caller
`ifndef BRANCH_CONSTS_SVH
`define BRANCH_CONSTS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OP_REL_NZ 8'h20
`define OP_LOOP 8'h10
`define OP_PTR_JUMP 8'hE9
`define OP_PFX_FIRST 8'hDD
`define OP_PFX_SECOND 8'hFD

// ----------------------------------------------------------------
// t-state totals, each minus one as loaded into the counter
// ----------------------------------------------------------------
`define TS_REL_TAKEN 4'h0B
`define TS_REL_SKIP 4'h6
`define TS_PTR 4'h3
`define TS_IDX 4'h7
`define TS_LOOP_TAKEN 4'h0C
`define TS_LOOP_SKIP 4'h7
`define TS_UNKNOWN 4'h3

// ----------------------------------------------------------------
// address steps, loop-count and t-state counter constants
// ----------------------------------------------------------------
`define STEP_TWO 16'h0002
`define STEP_ONE 16'h0001
`define COUNT_ONE 8'h01
`define COUNT_ZERO 8'h00
`define CNT_ZERO 4'h0
`define CNT_STEP 4'h1
`define ADDR_ZERO 16'h0000

`endif

//--- branch_pkg.sv
// types shared by the branch executor and its port checker
// assumes branch_consts.svh for every number
package branch_pkg;

  // ----------------------------------------------------------------
  // request: bytes already fetched plus the register file view
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] op0;
    logic [7:0] op1;
    logic [15:0] op_addr;
    logic [15:0] primary_pair;
    logic [15:0] first_index;
    logic [15:0] second_index;
    logic [7:0] loop_count;
    logic [7:0] flags;
    logic zero_flag;
  } branch_req_t;

  // ----------------------------------------------------------------
  // result written back when the instruction ends
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] next_pointer;
    logic [7:0] loop_count;
    logic loop_count_wr;
    logic [7:0] flags;
    logic taken;
    logic unknown_op;
  } branch_res_t;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } exec_state_t;

endpackage

//--- disp_adder.sv
// relative target adder
// assumes op_addr is the address of the branch opcode byte
`include "branch_consts.svh"
`timescale 1ns/100ps
module disp_adder (
  // operands
  input wire logic [15:0] op_addr,
  input wire logic [7:0] disp,
  // results
  output logic [15:0] target,
  output logic [15:0] seq_next
);

  logic [15:0] disp_ext;

  always_comb begin
    disp_ext = {{8{disp[7]}}, disp};
    seq_next = op_addr + `STEP_TWO;
    // offset taken from the twice-advanced pointer, so reach is
    // -128+2 .. +127+2 around the opcode byte
    target = seq_next + disp_ext;
  end

endmodule

//--- branch_chk.sv
// port checker for the branch executor
// assumes one t-state per ref_clk cycle; bound onto branch_exec
`timescale 1ns/100ps
module branch_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // request and result
  input wire logic start,
  input wire branch_pkg::branch_req_t req,
  input wire logic busy,
  input wire logic done,
  input wire branch_pkg::branch_res_t res
);
  branch_pkg::branch_req_t req_ff, nxt_req;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] seq, tgt;
  logic [7:0] op;
  assign op = req_ff.op0;
  assign seq = req_ff.op_addr + 16'h0002;
  assign tgt = seq + {{8{req_ff.op1[7]}}, req_ff.op1};
  // counter saturates so a stray done never wraps into a match
  always_comb begin
    nxt_req = (start && !busy) ? req : req_ff;
    nxt_cnt = (start && !busy) ? 5'h00 : cnt_ff + {4'h0, ~&cnt_ff};
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_ff <= '0;
      cnt_ff <= 5'h1F;
    end else begin
      req_ff <= nxt_req;
      cnt_ff <= nxt_cnt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_rel_taken: assert property (
    done && op == 8'h20 && !req_ff.zero_flag
    |-> cnt_ff == 5'h0C && res.next_pointer == tgt)
    else $error("relative jump taken wrong");
  a_rel_skip: assert property (
    done && op == 8'h20 && req_ff.zero_flag
    |-> cnt_ff == 5'h07 && res.next_pointer == seq)
    else $error("relative jump skip wrong");
  a_ptr_jump: assert property (
    done && op == 8'hE9
    |-> cnt_ff == 5'h04 && res.next_pointer == req_ff.primary_pair)
    else $error("pointer jump wrong");
  a_index_jump: assert property (
    done && (op == 8'hDD || op == 8'hFD) && req_ff.op1 == 8'hE9
    |-> cnt_ff == 5'h08 && res.next_pointer == (op == 8'hDD ?
    req_ff.first_index : req_ff.second_index))
    else $error("index jump wrong");
  a_loop_taken: assert property (
    done && op == 8'h10 && req_ff.loop_count != 8'h01
    |-> cnt_ff == 5'h0D && res.next_pointer == tgt
    && res.loop_count == req_ff.loop_count - 8'h01)
    else $error("loop branch taken wrong");
  a_loop_exit: assert property (
    done && op == 8'h10 && req_ff.loop_count == 8'h01
    |-> cnt_ff == 5'h08 && res.next_pointer == seq
    && res.loop_count == 8'h00)
    else $error("loop fall through wrong");
  a_flags_kept: assert property (
    done |-> res.flags == req_ff.flags)
    else $error("flags changed");
  a_busy_span: assert property (
    start && !busy |=> busy [*4])
    else $error("busy dropped early");
endmodule
bind branch_exec branch_chk chk (.ref_clk(ref_clk), .rstn(rstn),
  .start(start), .req(req), .busy(busy), .done(done), .res(res));

//--- tb_top.sv
// self-checking bench for the branch executor
// assumes the checker is bound in; inputs move 1 ns after each edge
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  branch_pkg::branch_req_t req = '0;
  logic busy;
  logic done;
  branch_pkg::branch_res_t res;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 67;
  int cyc = 0;
  logic [7:0] o;
  logic [7:0] ops [6] = '{8'h20, 8'h10, 8'hE9, 8'hDD, 8'hFD, 8'h00};
  branch_exec dut (.ref_clk(ref_clk), .rstn(rstn), .start(start),
    .req(req), .busy(busy), .done(done), .res(res));
  initial forever #10 ref_clk = ~ref_clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ceiling well above 50 runs of at most 14 cycles
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // returns {cycles, next pointer}
  function automatic logic [23:0] expect_of(branch_pkg::branch_req_t r);
    logic [15:0] sq;
    logic [15:0] tg;
    sq = r.op_addr + 16'h0002;
    tg = sq + {{8{r.op1[7]}}, r.op1};
    case (r.op0)
      8'h20: return r.zero_flag ? {8'h07, sq} : {8'h0C, tg};
      8'h10: return (r.loop_count == 8'h01) ? {8'h08, sq} : {8'h0D, tg};
      8'hE9: return {8'h04, r.primary_pair};
      8'hDD: if (r.op1 == 8'hE9) return {8'h08, r.first_index};
      8'hFD: if (r.op1 == 8'hE9) return {8'h08, r.second_index};
      default: ;
    endcase
    return {8'h04, r.op_addr + 16'h0001};
  endfunction
  // returns {taken, unknown_op, loop_count_wr}
  function automatic logic [2:0] status_of(branch_pkg::branch_req_t r);
    case (r.op0)
      8'h20: return {!r.zero_flag, 1'b0, 1'b0};
      8'h10: return {r.loop_count != 8'h01, 1'b0, 1'b1};
      8'hE9: return 3'h4;
      8'hDD, 8'hFD: return (r.op1 == 8'hE9) ? 3'h4 : 3'h2;
      default: return 3'h2;
    endcase
  endfunction
  task automatic run(logic [7:0] o0, logic [7:0] o1, logic zf,
                     logic [7:0] lc);
    branch_pkg::branch_req_t r;
    logic [23:0] e;
    logic [15:0] n;
    logic [2:0] s;
    logic [2:0] st;
    r = 97'({$random(seed), $random(seed), $random(seed), $random(seed)});
    r.op0 = o0;
    r.op1 = o1;
    r.zero_flag = zf;
    r.loop_count = lc;
    e = expect_of(r);
    s = status_of(r);
    req = r;
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    n = 16'h0000;
    do begin
      @(posedge ref_clk);
      #1;
      n = n + 16'h0001;
    end while (done !== 1'b1 && n < 16'h0014);
    check("cycles", n, {8'h00, e[23:16]});
    check("next_pointer", res.next_pointer, e[15:0]);
    check("flags", {8'h00, res.flags}, {8'h00, r.flags});
    st = {res.taken, res.unknown_op, res.loop_count_wr};
    check("status", {13'h0000, st}, {13'h0000, s});
    if (o0 == 8'h10) check("loop_count", {8'h00, res.loop_count},
      {8'h00, lc - 8'h01});
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    run(8'h20, 8'h7F, 1'b0, 8'h00);
    run(8'h20, 8'h80, 1'b0, 8'h00);
    run(8'h20, 8'h03, 1'b1, 8'h00);
    run(8'h10, 8'h80, 1'b0, 8'h02);
    run(8'h10, 8'h7F, 1'b0, 8'h01);
    run(8'h10, 8'hFA, 1'b0, 8'h00);
    run(8'hE9, 8'h00, 1'b0, 8'h00);
    run(8'hDD, 8'hE9, 1'b0, 8'h00);
    run(8'hFD, 8'hE9, 1'b0, 8'h00);
    run(8'hDD, 8'h00, 1'b0, 8'h00);
    $display("corner cases done");
    repeat (40) begin
      o = ops[$unsigned($random(seed)) % 6];
      run(o, ($random(seed) & 1) ? 8'hE9 : 8'($random(seed)),
        1'($random(seed)), 8'($random(seed)));
    end
    $display("random mix done");
    complete_run();
  end
endmodule
